// File: include/bmr_pkg.sv
package bmr_pkg;

    // address map
    localparam logic [31:0] BOOT_TOP     = 32'h000F_FFFF;
    localparam logic [31:0] ITCM_BASE    = 32'h0010_0000;
    localparam logic [31:0] DTCM_BASE    = 32'h0020_0000;
    localparam logic [31:0] SRAM_BASE    = 32'h0030_0000;
    localparam logic [31:0] ROM_BASE     = 32'h0040_0000;
    localparam logic [19:0] INT_WIN_MASK = 20'hF_FFFF;
    localparam logic [3:0]  BANK_INT     = 4'h0;
    localparam logic [3:0]  BANK_EXT_LO  = 4'h1;
    localparam logic [3:0]  BANK_EXT_HI  = 4'h6;
    localparam logic [3:0]  BANK_DDR     = 4'h7;
    localparam logic [3:0]  BANK_PERIPH  = 4'hF;
    localparam logic [11:0] SUB_BOOT     = 12'h000;
    localparam logic [11:0] SUB_ITCM     = 12'h001;
    localparam logic [11:0] SUB_DTCM     = 12'h002;
    localparam logic [11:0] SUB_SRAM     = 12'h003;
    localparam logic [11:0] SUB_ROM      = 12'h004;

    // reset values
    localparam logic        REMAP_RST    = 1'b0;
    localparam logic        BOOT_ROM_RST = 1'b1;

    // static memory controller boot defaults
    localparam logic [1:0]  SMC_WIDTH_16 = 2'h1;
    localparam logic        SMC_BYTE_SEL = 1'b1;
    localparam logic        SMC_RW_BY_CS = 1'b1;

    // slave targets
    typedef enum logic [3:0] {
        BMR_TGT_ABORT = 4'h0,
        BMR_TGT_ROM   = 4'h1,
        BMR_TGT_SRAM  = 4'h2,
        BMR_TGT_ITCM  = 4'h3,
        BMR_TGT_DTCM  = 4'h4,
        BMR_TGT_EXT   = 4'h5,
        BMR_TGT_DDR   = 4'h6,
        BMR_TGT_PERIPH = 4'h7
    } bmr_tgt_t;

    // decode result
    typedef struct packed {
        logic       hit;
        bmr_tgt_t   tgt;
        logic [2:0] ext_cs;
        logic [31:0] offs;
    } bmr_sel_t;

    // static memory controller default config
    typedef struct packed {
        logic [2:0] cs;
        logic       byte_sel;
        logic [1:0] width;
        logic       rw_by_cs;
    } bmr_smc_cfg_t;

    // boot decoder state
    typedef enum logic [1:0] {
        BMR_ST_SAMPLE = 2'b00,
        BMR_ST_BOOT   = 2'b01,
        BMR_ST_REMAP  = 2'b11
    } bmr_st_t;

endpackage

// File: core/bmr_decoder.sv
`timescale 1ns/1ps
// Function
// - first fetch after reset comes from address zero via the boot mapping.
// - boot region owner chosen by boot select pin level sampled at reset.
// - boot select high routes boot region to embedded ROM.
// - boot select low routes boot region to external chip select zero.
// - addresses zero to 0x000F_FFFF form the boot region only.
// - after software remap command, internal SRAM answers at address zero.
// - every memory stays reachable at its own base address always.
// - external boot sets STATIC_MEMORY_CTRL to CS0, byte select, 16-bit, strobes by CS.
// - before remap, SRAM is reachable only at its fixed base.
// - accesses to unused areas return an abort to the master.
// - 16 banks of 256 MB; banks 1 to 6 go to external chip selects.
module bmr_decoder (
    input  wire logic                  clk,             // 200 MHz bus clock
    input  wire logic                  nrst,            // synchronous reset, active low
    input  wire logic                  boot_select_pin, // strap pin, asynchronous
    input  wire logic                  remap_cmd,       // one-cycle remap command pulse
    input  wire logic                  req_valid,       // master request valid
    input  wire logic [31:0]           req_addr,        // master byte address
    output logic                       sel_valid,       // decode result valid (comb)
    output bmr_pkg::bmr_sel_t          sel_q,           // registered decode result
    output logic                       abort_q,         // registered abort answer
    output logic                       boot_rom_q,      // latched boot select level
    output logic                       remap_q,         // remap done
    output bmr_pkg::bmr_smc_cfg_t      smc_cfg_q        // static memory ctrl defaults
);

    // three-stage pin sync; first stage feeds only the second
    logic [2:0] pin_sync_q;
    logic [2:0] pin_sync_d;
    bmr_pkg::bmr_st_t st_q, st_d;
    logic boot_rom_d, remap_d;
    bmr_pkg::bmr_sel_t sel_d;
    logic abort_d;
    bmr_pkg::bmr_smc_cfg_t smc_cfg_d;
    logic req_seen_q;

    // combinational address decode used for any master address
    function automatic bmr_pkg::bmr_sel_t decode(input logic [31:0] a,
                                                  input logic        rom_boot,
                                                  input logic        remapped);
        bmr_pkg::bmr_sel_t s;
        logic [3:0]  bank;
        logic [11:0] sub;
        s = '0;
        bank = a[31:28];
        sub  = a[31:20];
        s.offs = {12'h000, a[19:0] & bmr_pkg::INT_WIN_MASK};
        s.hit  = 1'b1;
        if (bank == bmr_pkg::BANK_INT) begin
            case (sub)
                bmr_pkg::SUB_BOOT: begin
                    if (remapped)
                        s.tgt = bmr_pkg::BMR_TGT_SRAM;
                    else if (rom_boot)
                        s.tgt = bmr_pkg::BMR_TGT_ROM;
                    else begin
                        s.tgt    = bmr_pkg::BMR_TGT_EXT;
                        s.ext_cs = 3'h0;
                    end
                end
                bmr_pkg::SUB_ITCM: s.tgt = bmr_pkg::BMR_TGT_ITCM;
                bmr_pkg::SUB_DTCM: s.tgt = bmr_pkg::BMR_TGT_DTCM;
                bmr_pkg::SUB_SRAM: s.tgt = bmr_pkg::BMR_TGT_SRAM;
                bmr_pkg::SUB_ROM:  s.tgt = bmr_pkg::BMR_TGT_ROM;
                default: begin
                    s.hit = 1'b0;
                    s.tgt = bmr_pkg::BMR_TGT_ABORT;
                end
            endcase
        end else if (bank >= bmr_pkg::BANK_EXT_LO && bank <= bmr_pkg::BANK_EXT_HI) begin
            // external banks keep full 256 MB offset
            s.tgt    = bmr_pkg::BMR_TGT_EXT;
            s.ext_cs = 3'(bank - bmr_pkg::BANK_EXT_LO);
            s.offs   = {4'h0, a[27:0]};
        end else if (bank == bmr_pkg::BANK_DDR) begin
            s.tgt  = bmr_pkg::BMR_TGT_DDR;
            s.offs = {4'h0, a[27:0]};
        end else if (bank == bmr_pkg::BANK_PERIPH) begin
            s.tgt  = bmr_pkg::BMR_TGT_PERIPH;
            s.offs = {4'h0, a[27:0]};
        end else begin
            s.hit = 1'b0;
            s.tgt = bmr_pkg::BMR_TGT_ABORT;
        end
        return s;
    endfunction

    // boot state: sample the strap once sync is settled, then hold it
    always_comb begin
        pin_sync_d = {pin_sync_q[1:0], boot_select_pin};
        st_d       = st_q;
        boot_rom_d = boot_rom_q;
        remap_d    = remap_q;
        smc_cfg_d  = smc_cfg_q;
        case (st_q)
            bmr_pkg::BMR_ST_SAMPLE: begin
                // wait until stages two and three agree before trusting the strap
                if (pin_sync_q[2] == pin_sync_q[1] && req_seen_q) begin
                    boot_rom_d = pin_sync_q[2];
                    st_d       = bmr_pkg::BMR_ST_BOOT;
                    smc_cfg_d.cs       = 3'h0;
                    smc_cfg_d.byte_sel = bmr_pkg::SMC_BYTE_SEL;
                    smc_cfg_d.width    = bmr_pkg::SMC_WIDTH_16;
                    smc_cfg_d.rw_by_cs = bmr_pkg::SMC_RW_BY_CS;
                end
            end
            bmr_pkg::BMR_ST_BOOT: begin
                if (remap_cmd) begin
                    remap_d = 1'b1;
                    st_d    = bmr_pkg::BMR_ST_REMAP;
                end
            end
            bmr_pkg::BMR_ST_REMAP: st_d = bmr_pkg::BMR_ST_REMAP;
            default: st_d = bmr_pkg::BMR_ST_SAMPLE;
        endcase
    end

    // sync keeps shifting through reset: zeroed stages would look settled and latch a false strap
    always_ff @(posedge clk) begin
        pin_sync_q <= pin_sync_d;
        if (!nrst) begin
            st_q       <= bmr_pkg::BMR_ST_SAMPLE;
            boot_rom_q <= bmr_pkg::BOOT_ROM_RST;
            remap_q    <= bmr_pkg::REMAP_RST;
            smc_cfg_q  <= '0;
            req_seen_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            boot_rom_q <= boot_rom_d;
            remap_q    <= remap_d;
            smc_cfg_q  <= smc_cfg_d;
            req_seen_q <= pin_sync_q[2] == pin_sync_q[1];
        end
    end

    // masters may only issue once the strap is settled
    assign sel_valid = req_valid && (st_q != bmr_pkg::BMR_ST_SAMPLE);

    // registered decode answer, one cycle after the request
    always_comb begin
        sel_d   = decode(req_addr, boot_rom_q, remap_q);
        abort_d = sel_valid && !sel_d.hit;
        if (!sel_valid)
            sel_d = '0;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sel_q   <= '0;
            abort_q <= 1'b0;
        end else begin
            sel_q   <= sel_d;
            abort_q <= abort_d;
        end
    end

    // boot region answers with the chosen memory
    boot_rom_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr <= bmr_pkg::BOOT_TOP && boot_rom_q && !remap_q
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_ROM)
        else $error("boot region not on rom");
    boot_ext_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr <= bmr_pkg::BOOT_TOP && !boot_rom_q && !remap_q
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_EXT && sel_q.ext_cs == 3'h0)
        else $error("boot region not on cs0");
    remap_sram_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr <= bmr_pkg::BOOT_TOP && remap_q
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_SRAM)
        else $error("remap not showing sram");
    rom_fixed_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr[31:20] == bmr_pkg::SUB_ROM
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_ROM)
        else $error("rom lost at its base");
    sram_base_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr[31:20] == bmr_pkg::SUB_SRAM
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_SRAM)
        else $error("sram lost at its base");
    unused_abort_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr[31:28] >= 4'h8 && req_addr[31:28] <= 4'hE
        |=> abort_q)
        else $error("unused bank not aborted");
    ext_bank_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr[31:28] == 4'h3
        |=> sel_q.tgt == bmr_pkg::BMR_TGT_EXT && sel_q.ext_cs == 3'h2)
        else $error("bank 3 not on cs2");
    strap_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q != bmr_pkg::BMR_ST_SAMPLE |=> $stable(boot_rom_q))
        else $error("strap level changed after sampling");
    smc_boot_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q != bmr_pkg::BMR_ST_SAMPLE
        |-> smc_cfg_q.width == bmr_pkg::SMC_WIDTH_16 && smc_cfg_q.cs == 3'h0)
        else $error("smc defaults wrong");

    // strap capture, boot window confinement, remap take-up and bank 0 holes
    strap_high_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == bmr_pkg::BMR_ST_SAMPLE && st_d == bmr_pkg::BMR_ST_BOOT && pin_sync_q[2]
        |=> boot_rom_q)
        else $error("high strap not latched");
    strap_low_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == bmr_pkg::BMR_ST_SAMPLE && st_d == bmr_pkg::BMR_ST_BOOT && !pin_sync_q[2]
        |=> !boot_rom_q)
        else $error("low strap not latched");
    boot_window_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr <= bmr_pkg::BOOT_TOP
        |=> sel_q.hit && sel_q.offs[31:20] == 12'h000)
        else $error("boot region offset outside window");
    remap_take_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == bmr_pkg::BMR_ST_BOOT && remap_cmd
        |=> remap_q)
        else $error("remap command not taken");
    sub_abort_a: assert property (@(posedge clk) disable iff (!nrst)
        sel_valid && req_addr[31:28] == bmr_pkg::BANK_INT && req_addr[31:20] > bmr_pkg::SUB_ROM
        |=> abort_q && !sel_q.hit)
        else $error("unused internal area not aborted");

endmodule

// File: dv/bmr_bus_master.sv
`timescale 1ns/1ps
// bus master stand-in: registers one request per go cycle
module bmr_bus_master (
    input  wire logic        clk,       // bus clock
    input  wire logic        go,        // issue a request this cycle
    input  wire logic [31:0] addr_in,   // address to issue
    output logic             req_valid, // request valid
    output logic [31:0]      req_addr   // request address
);
    initial req_addr = 32'h0000_0000;
    // idle address flips each cycle so a stale value never looks like a request
    always @(posedge clk) begin
        req_valid <= go;
        req_addr  <= go ? addr_in : ~req_addr;
    end
endmodule

// File: dv/boot_memory_remap_decoder_tb_top.sv
`timescale 1ns/1ps
module boot_memory_remap_decoder_tb_top;
    logic                  clk, nrst, pin, remap_cmd, go, req_valid;
    logic                  sel_valid, abort_q, boot_rom_q, remap_q, exp_rom, exp_rmp;
    logic [31:0]           a_in, req_addr;
    bmr_pkg::bmr_sel_t     sel_q, e;
    bmr_pkg::bmr_smc_cfg_t smc_cfg_q;
    bmr_pkg::bmr_sel_t     q[$];
    int                    num_errors, checks, seed, cyc;

    bmr_bus_master MST (.clk(clk), .go(go), .addr_in(a_in), .req_valid(req_valid),
                        .req_addr(req_addr));
    bmr_decoder DUT (.clk(clk), .nrst(nrst), .boot_select_pin(pin), .remap_cmd(remap_cmd),
                     .req_valid(req_valid), .req_addr(req_addr), .sel_valid(sel_valid),
                     .sel_q(sel_q), .abort_q(abort_q), .boot_rom_q(boot_rom_q),
                     .remap_q(remap_q), .smc_cfg_q(smc_cfg_q));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(string n, logic [38:0] x, logic [38:0] g);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // reference map worked out from the address plan
    function automatic bmr_pkg::bmr_sel_t exp_of(logic [31:0] a);
        bmr_pkg::bmr_sel_t s;
        s = '0;
        s.hit = 1'b1;
        s.offs = {4'h0, a[27:0]};
        if (a[31:28] == bmr_pkg::BANK_INT) begin
            case (a[31:20])
                bmr_pkg::SUB_BOOT: s.tgt = exp_rmp ? bmr_pkg::BMR_TGT_SRAM :
                    (exp_rom ? bmr_pkg::BMR_TGT_ROM : bmr_pkg::BMR_TGT_EXT);
                bmr_pkg::SUB_ITCM: s.tgt = bmr_pkg::BMR_TGT_ITCM;
                bmr_pkg::SUB_DTCM: s.tgt = bmr_pkg::BMR_TGT_DTCM;
                bmr_pkg::SUB_SRAM: s.tgt = bmr_pkg::BMR_TGT_SRAM;
                bmr_pkg::SUB_ROM:  s.tgt = bmr_pkg::BMR_TGT_ROM;
                default:           s.hit = 1'b0;
            endcase
        end else if (a[31:28] <= bmr_pkg::BANK_EXT_HI) begin
            s.tgt = bmr_pkg::BMR_TGT_EXT;
            s.ext_cs = a[30:28] - 3'h1;
        end else if (a[31:28] == bmr_pkg::BANK_DDR) s.tgt = bmr_pkg::BMR_TGT_DDR;
        else if (a[31:28] == bmr_pkg::BANK_PERIPH) s.tgt = bmr_pkg::BMR_TGT_PERIPH;
        else s.hit = 1'b0;
        if (!s.hit) s.tgt = bmr_pkg::BMR_TGT_ABORT;
        return s;
    endfunction

    // watcher: every answer takes the oldest note off the queue
    always @(negedge clk) begin
        if (sel_q.hit === 1'b1 || abort_q === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : '1;
            chk("target", {34'h0, e.hit, e.tgt}, {34'h0, sel_q.hit, sel_q.tgt});
            chk("abort", {38'h0, !e.hit}, {38'h0, abort_q});
            if (e.tgt == bmr_pkg::BMR_TGT_EXT)
                chk("cs_offs", {4'h0, e.ext_cs, e.offs}, {4'h0, sel_q.ext_cs, sel_q.offs});
        end
    end

    task automatic rst(logic p, logic pulse);
        @(posedge clk) pin <= p;
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        remap_cmd <= pulse;
        @(posedge clk) remap_cmd <= 1'b0;
        for (int i = 0; i < 20 && sel_valid !== 1'b1; i++) @(negedge clk);
        exp_rom = p;
        exp_rmp = 1'b0;
    endtask

    // boot window, each internal block, an unused sub-block, then banks 1 to 15
    task automatic sweep();
        logic [31:0] a;
        for (int i = 0; i < 21; i++) begin
            a = $random(seed);
            a[31:20] = (i < 6) ? 12'(i) : {4'(i - 5), a[27:20]};
            @(posedge clk) go <= 1'b1;
            a_in <= a;
            q.push_back(exp_of(a));
        end
        @(posedge clk) go <= 1'b0;
        @(negedge clk) chk("sel_valid", 39'h1, 39'(sel_valid));
        repeat (2) @(negedge clk);
        chk("drained", 39'h0, 39'(q.size()));
    endtask

    initial begin
        seed = 32'hf088;
        {nrst, remap_cmd, go, num_errors, checks, cyc} = '0;
        pin = 1'b1;
        a_in = 32'h0000_0000;
        rst(1'b1, 1'b0);
        chk("rom_boot", 39'h1, 39'(boot_rom_q));
        chk("smc", 39'({3'h0, bmr_pkg::SMC_BYTE_SEL, bmr_pkg::SMC_WIDTH_16,
            bmr_pkg::SMC_RW_BY_CS}), 39'(smc_cfg_q));
        @(posedge clk) pin <= 1'b0;
        sweep();
        chk("held", 39'h1, 39'(boot_rom_q));
        @(posedge clk) remap_cmd <= 1'b1;
        @(posedge clk) remap_cmd <= 1'b0;
        @(negedge clk) chk("remap", 39'h1, 39'(remap_q));
        exp_rmp = 1'b1;
        sweep();
        // a remap pulse while the strap is still being sampled is dropped
        rst(1'b0, 1'b1);
        chk("no_remap", 39'h0, 39'(remap_q));
        chk("ext_boot", 39'h0, 39'(boot_rom_q));
        chk("smc_ext", 39'({3'h0, bmr_pkg::SMC_BYTE_SEL, bmr_pkg::SMC_WIDTH_16,
            bmr_pkg::SMC_RW_BY_CS}), 39'(smc_cfg_q));
        sweep();
        close_out();
    end
endmodule
